/* hw/hbc_pkg.sv */
// Shared constants of the host bridge command and status registers
package hbc_pkg;

    // ------------------------------------------------------------------
    // Configuration offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_BRIDGE_COMMAND = 8'h04;
    localparam logic [7:0] OFF_BRIDGE_STATUS = 8'h06;
    localparam int CFG_ADDR_W = 8;
    localparam int CFG_DATA_W = 32;
    localparam int CFG_BE_W = 4;
    localparam int REG_W = 16;

    // ------------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------------
    localparam int CMD_IO_ACCESS_ON = 0;
    localparam int CMD_MEMORY_ACCESS_ON = 1;
    localparam int CMD_BUS_MASTER_ON = 2;
    localparam int CMD_WRITE_INVALIDATE_ENABLE = 4;
    localparam int CMD_PALETTE_SNOOP_ENABLE = 5;
    localparam int CMD_PARITY_ERR_ENABLE = 6;
    localparam int CMD_ADDR_DATA_STEPPING = 7;
    localparam int CMD_SYSERR_MSG_ENABLE = 8;
    localparam int CMD_FAST_B2B_BIT = 9;
    localparam logic [15:0] CMD_RESET = 16'h0006;
    localparam logic CMD_SYSERR_MSG_ENABLE_RST = 1'b0;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int STS_CAPABILITY_LIST_FLAG = 4;
    localparam int STS_66MHZ_CAPABLE = 5;
    localparam int STS_FAST_B2B_CAPABLE = 7;
    localparam int STS_MASTER_PARITY_ERR = 8;
    localparam int STS_SELECT_TIMING_LO = 9;
    localparam int STS_SELECT_TIMING_HI = 10;
    localparam int STS_TARGET_ABORT_SENT = 11;
    localparam int STS_COMPLETER_ABORT_RECEIVED = 12;
    localparam int STS_UNSUPPORTED_REQ_RECEIVED = 13;
    localparam int STS_SYSERR_SENT_FLAG = 14;
    localparam int STS_DETECTED_PARITY_ERR = 15;
    localparam logic [15:0] STS_RESET = 16'h0090;
    localparam logic STS_FLAG_RST = 1'b0;

    // ------------------------------------------------------------------
    // Completion status codes seen on the chipset link
    // ------------------------------------------------------------------
    localparam int CPL_STATUS_W = 3;
    localparam logic [2:0] CPL_SUCCESS = 3'h1 - 3'h1;
    localparam logic [2:0] CPL_UNSUPPORTED = 3'h1;
    localparam logic [2:0] CPL_COMPLETER_ABORT = 3'h4;

    // Message sender states
    typedef enum logic [1:0] {
        MSG_IDLE,
        MSG_REQ,
        MSG_HOLD
    } hbc_msg_state_t;

endpackage : hbc_pkg

/* hw/hbc_w1c_flag.sv */
// Sticky event flag cleared by software writing one
`timescale 1ns/100ps
module hbc_w1c_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic set_evt,
    input wire logic clr_req,
    output logic flag_q
);
    import hbc_pkg::*;

    logic flag_d;

    // Set beats clear so an event in the clearing cycle survives
    assign flag_d = set_evt | (flag_q & ~clr_req);

    // ------------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= STS_FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule : hbc_w1c_flag

/* hw/hbc_msg_sender.sv */
// Hands system-error messages to the chipset link transmitter
`timescale 1ns/100ps
module hbc_msg_sender (
    input wire logic clk,
    input wire logic rst,
    input wire logic trigger,
    input wire logic mech_on,
    input wire logic ack,
    output logic req_q,
    output logic sent_q
);
    import hbc_pkg::*;

    hbc_msg_state_t state_q;
    hbc_msg_state_t state_d;
    logic pend_q;
    logic pend_d;
    logic req_d;
    logic sent_d;
    logic take;

    // Request is accepted by the transmitter on req with ack
    assign take = req_q & ack;
    // Further triggers while busy merge into one extra message
    assign pend_d = trigger | (pend_q & ~(state_q == MSG_IDLE & mech_on));

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        req_d = req_q;
        sent_d = 1'b0;
        case (state_q)
            MSG_IDLE: begin
                if (pend_q & mech_on) begin
                    state_d = MSG_REQ;
                    req_d = 1'b1;
                end
            end
            MSG_REQ: begin
                if (take) begin
                    state_d = MSG_HOLD;
                    req_d = 1'b0;
                    sent_d = 1'b1;
                end
            end
            MSG_HOLD: begin
                // Two idle cycles between messages, this one and MSG_IDLE
                state_d = MSG_IDLE;
            end
            default: begin
                state_d = MSG_IDLE;
                req_d = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= MSG_IDLE;
            pend_q <= 1'b0;
            req_q <= 1'b0;
            sent_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            req_q <= req_d;
            sent_q <= sent_d;
        end
    end

endmodule : hbc_msg_sender

/* hw/hbc_cmd_status_regs.sv */
// Host bridge command and status configuration registers
//
// How it works
// - System-error enable resets to zero, blocks messages.
// - Enabled with error enabled sends link message.
// - No error pin; report only by message.
// - Functions 0,1,3 enables ORed gate mechanism.
// - Bus master bit hardwired one.
// - Memory access bit one; command resets 0006.
// - Other command capability bits read zero.
// - No write-invalidate, no fast back-to-back master.
// - Message sent flag, write one clears.
// - Unsupported request completion flag, write one clears.
// - Completer abort completion flag, write one clears.
// - Target abort sent bit hardwired zero.
// - Select timing bits hardwired 00.
// - Fast back-to-back capable status bit one.
// - 66 MHz capable bit hardwired zero.
// - Parity status bits zero; status resets 0090.
// - Capability list status bit hardwired one.
//
// Only the command/status dword decodes here;
// other offsets read zero.
`timescale 1ns/100ps
module hbc_cmd_status_regs #(
    parameter int N_ERR = 8
) (
    input wire logic MCLK,
    input wire logic RST,

    // Configuration access, dword addressed by byte offset
    input wire logic CFG_RD,
    input wire logic CFG_WR,
    input wire logic [hbc_pkg::CFG_ADDR_W-1:0] CFG_ADDR,
    input wire logic [hbc_pkg::CFG_BE_W-1:0] CFG_BE,
    input wire logic [hbc_pkg::CFG_DATA_W-1:0] CFG_WDATA,
    output logic [hbc_pkg::CFG_DATA_W-1:0] CFG_RDATA,
    output logic CFG_DONE,

    // Host bridge error conditions and their individual enables
    input wire logic [N_ERR-1:0] ERR_EVENT,
    input wire logic [N_ERR-1:0] ERR_ENABLE,

    // Error enables of the sibling functions 1 and 3
    input wire logic PEER1_SYSERR_EN,
    input wire logic PEER3_SYSERR_EN,

    // Completions returned for requests this device issued
    input wire logic CPL_VALID,
    input wire logic [hbc_pkg::CPL_STATUS_W-1:0] CPL_STATUS,

    // System-error message towards the link transmitter
    output logic SYSERR_MSG_REQ,
    input wire logic SYSERR_MSG_ACK,

    // Live copies of command state for the rest of the bridge
    output logic SYSERR_MSG_ENABLE,
    output logic BUS_MASTER_ON,
    output logic MEMORY_ACCESS_ON
);
    import hbc_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Command enable
    logic syserr_en_q;
    logic syserr_en_d;

    // Sticky flags
    logic syserr_flag_q;
    logic ur_flag_q;
    logic ca_flag_q;

    // Bus answer
    logic [CFG_DATA_W-1:0] rdata_q;
    logic [CFG_DATA_W-1:0] rdata_d;
    logic done_q;
    logic done_d;

    // Flopped outputs
    logic master_on_q;
    logic mem_on_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Status half offset
    localparam int STS_LANE = 8 * (int'(OFF_BRIDGE_STATUS) - int'(OFF_BRIDGE_COMMAND));
    // Dword select top bit
    localparam int DW_MSB = CFG_ADDR_W - 1;

    // Decoded strobes
    logic hit;
    logic cmd_hi_wr;
    logic sts_hi_wr;
    logic [REG_W-1:0] sts_wdata;

    // Both registers share the dword at the command offset
    assign hit = CFG_ADDR[DW_MSB:2] == OFF_BRIDGE_COMMAND[DW_MSB:2];

    // Upper byte of command holds the only writable bit
    assign cmd_hi_wr = CFG_WR & hit & CFG_BE[1];

    // Upper byte of status holds all clearable flags
    assign sts_hi_wr = CFG_WR & hit & CFG_BE[3];
    // Written status half
    assign sts_wdata = CFG_WDATA[STS_LANE +: REG_W];

    // ------------------------------------------------------------------
    // Command register write
    // ------------------------------------------------------------------
    // Bit 8 as written
    logic wr_syserr_en;

    // Other command bits are read only, so data there is dropped
    assign wr_syserr_en = CFG_WDATA[CMD_SYSERR_MSG_ENABLE];

    // Kept unless written
    assign syserr_en_d = cmd_hi_wr ? wr_syserr_en : syserr_en_q;

    // Writable enable plus flopped copies of the hardwired ones
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            // Set from reset
            syserr_en_q <= CMD_SYSERR_MSG_ENABLE_RST;
            master_on_q <= CMD_RESET[CMD_BUS_MASTER_ON];
            mem_on_q <= CMD_RESET[CMD_MEMORY_ACCESS_ON];
        end else begin
            syserr_en_q <= syserr_en_d;
            // Reloaded each cycle
            master_on_q <= CMD_RESET[CMD_BUS_MASTER_ON];
            mem_on_q <= CMD_RESET[CMD_MEMORY_ACCESS_ON];
        end
    end

    // ------------------------------------------------------------------
    // Command register read image
    // ------------------------------------------------------------------
    // Command read view
    logic [REG_W-1:0] cmd_image;

    // Starts from the reset image; only bit 8 is live
    always_comb begin
        cmd_image = CMD_RESET;

        // Hardwired ones
        cmd_image[CMD_BUS_MASTER_ON] = 1'b1;
        cmd_image[CMD_MEMORY_ACCESS_ON] = 1'b1;

        // Unused capabilities read zero
        cmd_image[CMD_IO_ACCESS_ON] = 1'b0;
        cmd_image[CMD_WRITE_INVALIDATE_ENABLE] = 1'b0;
        cmd_image[CMD_PALETTE_SNOOP_ENABLE] = 1'b0;
        cmd_image[CMD_PARITY_ERR_ENABLE] = 1'b0;
        cmd_image[CMD_ADDR_DATA_STEPPING] = 1'b0;
        cmd_image[CMD_FAST_B2B_BIT] = 1'b0;

        // Live bit
        cmd_image[CMD_SYSERR_MSG_ENABLE] = syserr_en_q;
    end

    // ------------------------------------------------------------------
    // System-error message path
    // ------------------------------------------------------------------
    // Handshake wires
    logic own_error;
    logic mech_on;
    logic msg_req;
    logic msg_sent;

    // Own conditions count only under own enable and their own mask
    assign own_error = syserr_en_q & |(ERR_EVENT & ERR_ENABLE);

    // Shared sender runs if any of the three functions allows it
    assign mech_on = syserr_en_q | PEER1_SYSERR_EN | PEER3_SYSERR_EN;

    // The link message is the only way an error leaves the bridge
    // A pending message waits while all enables are off
    hbc_msg_sender u_msg (
        .clk(MCLK),
        .rst(RST),
        .trigger(own_error),
        .mech_on(mech_on),
        .ack(SYSERR_MSG_ACK),
        .req_q(msg_req),
        .sent_q(msg_sent)
    );

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // Set events
    logic ur_evt;
    logic ca_evt;
    // Clear strobes
    logic clr_syserr;
    logic clr_ur;
    logic clr_ca;

    // Completion status decode; success and others leave flags alone
    assign ur_evt = CPL_VALID & (CPL_STATUS == CPL_UNSUPPORTED);
    assign ca_evt = CPL_VALID & (CPL_STATUS == CPL_COMPLETER_ABORT);

    // A zero in the written data leaves the flag as it is
    assign clr_syserr = sts_hi_wr & sts_wdata[STS_SYSERR_SENT_FLAG];
    assign clr_ur = sts_hi_wr & sts_wdata[STS_UNSUPPORTED_REQ_RECEIVED];
    assign clr_ca = sts_hi_wr & sts_wdata[STS_COMPLETER_ABORT_RECEIVED];

    // Flag set once the transmitter has taken the message
    hbc_w1c_flag u_syserr_flag (
        .clk(MCLK),
        .rst(RST),
        .set_evt(msg_sent),
        .clr_req(clr_syserr),
        .flag_q(syserr_flag_q)
    );

    // Unsupported Request answer to one of our requests
    hbc_w1c_flag u_ur_flag (
        .clk(MCLK),
        .rst(RST),
        .set_evt(ur_evt),
        .clr_req(clr_ur),
        .flag_q(ur_flag_q)
    );

    // Completer Abort answer to one of our requests
    hbc_w1c_flag u_ca_flag (
        .clk(MCLK),
        .rst(RST),
        .set_evt(ca_evt),
        .clr_req(clr_ca),
        .flag_q(ca_flag_q)
    );

    // ------------------------------------------------------------------
    // Status register read image
    // ------------------------------------------------------------------
    // Status read view
    logic [REG_W-1:0] sts_image;

    // Capability bits come from the reset image; reserved stay zero
    always_comb begin
        sts_image = STS_RESET;

        // Fixed bits
        sts_image[STS_CAPABILITY_LIST_FLAG] = 1'b1;
        sts_image[STS_66MHZ_CAPABLE] = 1'b0;
        sts_image[STS_FAST_B2B_CAPABLE] = 1'b1;
        sts_image[STS_MASTER_PARITY_ERR] = 1'b0;
        sts_image[STS_SELECT_TIMING_LO] = 1'b0;
        sts_image[STS_SELECT_TIMING_HI] = 1'b0;
        sts_image[STS_TARGET_ABORT_SENT] = 1'b0;

        // Live flags
        sts_image[STS_COMPLETER_ABORT_RECEIVED] = ca_flag_q;
        sts_image[STS_UNSUPPORTED_REQ_RECEIVED] = ur_flag_q;
        sts_image[STS_SYSERR_SENT_FLAG] = syserr_flag_q;

        // Parity bit
        sts_image[STS_DETECTED_PARITY_ERR] = 1'b0;
    end

    // ------------------------------------------------------------------
    // Configuration answer
    // ------------------------------------------------------------------
    // Status high, command low
    logic [CFG_DATA_W-1:0] dword_image;

    // Other dwords of the space belong elsewhere and read as zero here
    assign dword_image = {sts_image, cmd_image};
    assign rdata_d = (CFG_RD & hit) ? dword_image : '0;

    // Every read or write is answered one cycle later
    assign done_d = CFG_RD | CFG_WR;

    // Read data is held until the next read answers
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rdata_q <= '0;
            done_q <= 1'b0;
        end else begin
            // Writes keep the last read data
            if (CFG_RD) begin
                rdata_q <= rdata_d;
            end
            done_q <= done_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    // Bus answer
    assign CFG_RDATA = rdata_q;
    assign CFG_DONE = done_q;

    // Link request
    assign SYSERR_MSG_REQ = msg_req;

    // Command state
    assign SYSERR_MSG_ENABLE = syserr_en_q;
    assign BUS_MASTER_ON = master_on_q;
    assign MEMORY_ACCESS_ON = mem_on_q;

endmodule : hbc_cmd_status_regs

/* test/hbc_cmd_status_regs_properties.sv */
// Port-level checker for the host bridge command and status registers
`timescale 1ns/100ps
module hbc_regs_chk #(
    parameter int N_ERR = 8
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CFG_RD,
    input wire logic CFG_WR,
    input wire logic [hbc_pkg::CFG_ADDR_W-1:0] CFG_ADDR,
    input wire logic [hbc_pkg::CFG_BE_W-1:0] CFG_BE,
    input wire logic [hbc_pkg::CFG_DATA_W-1:0] CFG_WDATA,
    input wire logic [hbc_pkg::CFG_DATA_W-1:0] CFG_RDATA,
    input wire logic CFG_DONE,
    input wire logic [N_ERR-1:0] ERR_EVENT,
    input wire logic [N_ERR-1:0] ERR_ENABLE,
    input wire logic PEER1_SYSERR_EN,
    input wire logic PEER3_SYSERR_EN,
    input wire logic CPL_VALID,
    input wire logic [hbc_pkg::CPL_STATUS_W-1:0] CPL_STATUS,
    input wire logic SYSERR_MSG_REQ,
    input wire logic SYSERR_MSG_ACK,
    input wire logic SYSERR_MSG_ENABLE,
    input wire logic BUS_MASTER_ON,
    input wire logic MEMORY_ACCESS_ON
);
    import hbc_pkg::*;
    // Decode of the shared dword and the message gate
    wire hit;
    wire en_wr;
    wire gate;
    assign hit = CFG_ADDR[7:2] == 6'h01;
    assign en_wr = CFG_WR && hit && CFG_BE[1];
    assign gate = SYSERR_MSG_ENABLE || PEER1_SYSERR_EN || PEER3_SYSERR_EN;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    chk_master_bits_on: assert property (BUS_MASTER_ON && MEMORY_ACCESS_ON)
        else $error("master or memory bit low");
    chk_enable_write: assert property (en_wr |=> SYSERR_MSG_ENABLE == $past(CFG_WDATA[8]))
        else $error("enable not written");
    chk_enable_hold: assert property (!en_wr |=> $stable(SYSERR_MSG_ENABLE))
        else $error("enable changed without write");
    chk_gate_before_req: assert property ($rose(SYSERR_MSG_REQ) |-> $past(gate))
        else $error("message request with gate closed");
    chk_req_waits_ack: assert property (SYSERR_MSG_REQ && !SYSERR_MSG_ACK |=> SYSERR_MSG_REQ)
        else $error("request dropped before ack");
    chk_req_drops_ack: assert property (SYSERR_MSG_REQ && SYSERR_MSG_ACK |=> !SYSERR_MSG_REQ)
        else $error("request held after ack");
    chk_cmd_image: assert property (CFG_RD && hit |=>
        CFG_RDATA[15:0] == {7'h00, $past(SYSERR_MSG_ENABLE), 8'h06})
        else $error("command image wrong");
    chk_sts_fixed_bits: assert property (CFG_RD && hit |=>
        (CFG_RDATA[31:16] & 16'h8FFF) == 16'h0090)
        else $error("status fixed bits wrong");
    chk_unmapped_zero: assert property (CFG_RD && !hit |=> CFG_RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!CFG_RD |=> $stable(CFG_RDATA))
        else $error("read data moved without read");
    chk_done_pulse: assert property (1'b1 |=> CFG_DONE == $past(CFG_RD || CFG_WR))
        else $error("done pulse mismatch");
    // Main traffic seen
    cover property (SYSERR_MSG_REQ && SYSERR_MSG_ACK);
    cover property (CPL_VALID && CPL_STATUS == CPL_COMPLETER_ABORT);
    cover property (en_wr && CFG_BE[3]);
endmodule : hbc_regs_chk

bind hbc_cmd_status_regs hbc_regs_chk #(.N_ERR(N_ERR)) chk_u (.MCLK(MCLK), .RST(RST),
    .CFG_RD(CFG_RD), .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
    .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_DONE(CFG_DONE),
    .ERR_EVENT(ERR_EVENT), .ERR_ENABLE(ERR_ENABLE), .PEER1_SYSERR_EN(PEER1_SYSERR_EN),
    .PEER3_SYSERR_EN(PEER3_SYSERR_EN), .CPL_VALID(CPL_VALID), .CPL_STATUS(CPL_STATUS),
    .SYSERR_MSG_REQ(SYSERR_MSG_REQ), .SYSERR_MSG_ACK(SYSERR_MSG_ACK),
    .SYSERR_MSG_ENABLE(SYSERR_MSG_ENABLE), .BUS_MASTER_ON(BUS_MASTER_ON),
    .MEMORY_ACCESS_ON(MEMORY_ACCESS_ON));

/* test/hbc_link_tx_model.sv */
// Behavioural link transmitter taking system-error messages
`timescale 1ns/100ps
module hbc_link_tx_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [3:0] delay,
    output logic ack
);
    logic [3:0] wait_q;
    // Stall for delay cycles, then ack one cycle; ack never lingers past it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_q <= 4'h0;
            ack <= 1'b0;
        end else if (req && !ack && wait_q != delay) begin
            wait_q <= wait_q + 4'h1;
        end else begin
            ack <= req && !ack;
            wait_q <= 4'h0;
        end
    end
endmodule : hbc_link_tx_model

/* test/hbc_cmd_status_regs_tb.sv */
// Self-checking bench for the host bridge command and status registers
`timescale 1ns/100ps
module hbc_cmd_status_regs_tb;
    import hbc_pkg::*;
    logic mclk, rst, cfg_rd, cfg_wr, cfg_done, cpl_valid, peer1, peer3;
    logic ack, msg_req, msg_en, bm_on, mem_on;
    logic [7:0] cfg_addr, err_event, err_enable;
    logic [3:0] cfg_be, ack_delay;
    logic [31:0] cfg_wdata, cfg_rdata, rd;
    logic [2:0] cpl_status;
    int errors, checks_done;

    // ----------------------------------------
    // Clock, design and link partner
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    hbc_cmd_status_regs dut_u (.MCLK(mclk), .RST(rst), .CFG_RD(cfg_rd), .CFG_WR(cfg_wr),
        .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata),
        .CFG_DONE(cfg_done), .ERR_EVENT(err_event), .ERR_ENABLE(err_enable),
        .PEER1_SYSERR_EN(peer1), .PEER3_SYSERR_EN(peer3), .CPL_VALID(cpl_valid),
        .CPL_STATUS(cpl_status), .SYSERR_MSG_REQ(msg_req), .SYSERR_MSG_ACK(ack),
        .SYSERR_MSG_ENABLE(msg_en), .BUS_MASTER_ON(bm_on), .MEMORY_ACCESS_ON(mem_on));
    hbc_link_tx_model tx_u (.clk(mclk), .rst(rst), .req(msg_req), .delay(ack_delay), .ack(ack));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // One config access; the answer comes on the same edge that takes it
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] wd);
        @(posedge mclk);
        cfg_rd <= ~wr;
        cfg_wr <= wr;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= wd;
        @(posedge mclk);
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b0;
        #1;
        if (cfg_done !== 1'b1) begin
            errors++;
            wrap_up();
        end
        rd = cfg_rdata;
    endtask : cfg
    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        while (msg_req !== lvl && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (msg_req !== lvl) begin
            errors++;
            wrap_up();
        end
    endtask : wait_req
    task automatic fire(input logic [7:0] ev, input logic [7:0] en, input logic p1, p3);
        @(posedge mclk);
        err_event <= ev;
        err_enable <= en;
        peer1 <= p1;
        peer3 <= p3;
        @(posedge mclk);
        err_event <= 8'h00;
    endtask : fire

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_image();
        cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
        check("image", rd, 32'h0090_0006);
        cfg(1'b0, 8'h06, 4'h0, 32'h0000_0000);
        check("image_hi", rd, 32'h0090_0006);
        cfg(1'b0, 8'h00, 4'h0, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        check("enable_rst", msg_en, 32'h0000_0000);
        check("bm_on", bm_on, 32'h0000_0001);
        check("mem_on", mem_on, 32'h0000_0001);
    endtask : t_reset_image
    task automatic t_cmd_write();
        cfg(1'b1, 8'h04, 4'hF, 32'hFFFF_FFFF);
        check("enable_on", msg_en, 32'h0000_0001);
        cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
        check("cmd_ones", rd, 32'h0090_0106);
        cfg(1'b1, 8'h04, 4'hD, 32'h0000_0000);
        check("lane_off", msg_en, 32'h0000_0001);
        cfg(1'b1, 8'h04, 4'h2, 32'h0000_0000);
        check("enable_off", msg_en, 32'h0000_0000);
        cfg(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
        cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
        check("stray_write", rd, 32'h0090_0006);
    endtask : t_cmd_write
    // Device enable low, peer only, or condition masked: no message at all
    task automatic t_msg_blocked();
        logic seen;
        for (int i = 0; i < 3; i++) begin
            cfg(1'b1, 8'h04, 4'h2, {23'h00_0000, i == 1, 8'h00});
            fire(8'h81, (i == 1) ? 8'h00 : 8'hFF, i == 0, i == 2);
            seen = 1'b0;
            repeat (8) begin
                @(posedge mclk);
                #1;
                seen |= msg_req;
            end
            check("blocked_req", seen, 32'h0000_0000);
            cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
            check("blocked_flag", rd[30], 32'h0000_0000);
        end
    endtask : t_msg_blocked
    // Prompt and stalled acceptance by the link, then flag clearing
    task automatic t_msg_sent();
        cfg(1'b1, 8'h04, 4'h2, 32'h0000_0100);
        for (int d = 0; d < 4; d += 3) begin
            @(posedge mclk);
            ack_delay <= 4'(d);
            fire(8'h04, 8'h04, 1'b0, 1'b0);
            wait_req(1'b1);
            wait_req(1'b0);
            repeat (2) @(posedge mclk);
            cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
            check("sent_flag", rd[30], 32'h0000_0001);
            cfg(1'b1, 8'h04, 4'h8, 32'h0000_0000);
            cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
            check("zero_write", rd[30], 32'h0000_0001);
            cfg(1'b1, 8'h04, 4'h8, 32'h4000_0000);
            cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
            check("w1_clear", rd, 32'h0090_0106);
        end
    endtask : t_msg_sent
    task automatic t_completions();
        logic [2:0] code [3];
        logic [31:0] exp [3];
        code = '{CPL_UNSUPPORTED, CPL_COMPLETER_ABORT, CPL_SUCCESS};
        exp = '{32'h2090_0106, 32'h1090_0106, 32'h0090_0106};
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            cpl_valid <= 1'b1;
            cpl_status <= code[i];
            @(posedge mclk);
            cpl_valid <= 1'b0;
            cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
            check("cpl_flag", rd, exp[i]);
            cfg(1'b1, 8'h04, 4'h8, 32'h3000_0000);
        end
        // Clear and a new abort in the same cycle: the abort must survive
        @(posedge mclk);
        cpl_valid <= 1'b1;
        cpl_status <= CPL_COMPLETER_ABORT;
        cfg_wr <= 1'b1;
        cfg_addr <= 8'h04;
        cfg_be <= 4'h8;
        cfg_wdata <= 32'h1000_0000;
        @(posedge mclk);
        cpl_valid <= 1'b0;
        cfg_wr <= 1'b0;
        cfg(1'b0, 8'h04, 4'h0, 32'h0000_0000);
        check("set_wins", rd[28], 32'h0000_0001);
    endtask : t_completions

    // Main sequence: two resets at the start, then a third reset after all the traffic
    initial begin
        {rst, cfg_rd, cfg_wr, cpl_valid, peer1, peer3} = 6'b10_0000;
        {cfg_addr, err_event, err_enable, cfg_be, ack_delay} = 32'h0000_0000;
        cfg_wdata = 32'h0000_0000;
        cpl_status = 3'h0;
        errors = 0;
        checks_done = 0;
        for (int r = 0; r < 2; r++) begin
            @(posedge mclk);
            rst <= 1'b1;
            repeat (8) @(posedge mclk);
            rst <= 1'b0;
            t_reset_image();
        end
        t_cmd_write();
        t_msg_blocked();
        t_msg_sent();
        t_completions();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset_image();
        wrap_up();
    end
endmodule : hbc_cmd_status_regs_tb
